// >>> core/pamx_top.sv
// Contract
// R1: SPI slave forces clock pin B5 to input; master leaves direction bit in charge.
// R2: SPI master forces data-in pin B4 to input; slave leaves direction bit in charge.
// R3: SPI slave forces data-out pin B3 to input; master uses its direction bit.
// R4: SPI slave forces select pin B2 to input; master uses its direction bit.
// R5: Slave SPI active only while select pin low; external master drives it low.
// R6: Pins forced to input by SPI keep pull-up controlled by output latch.
// R7: B4 feeds master input or carries slave output; B3 carries master out or slave in.
// R8: B3 drives timer2 compare when direction set; value is master out OR compare.
// R9: B2 drives timer1 compare B when enabled; software sets direction to output.
// R10: B1 drives timer1 compare A when enabled; direction must be output.
// R11: B0 input goes to timer1 capture; no override on that pin.
// R12: Internal RC or timer2 async turns off B6 pull-up, driver and input.
// R13: B7 overridden off when offchip clock and internal RC or timer2 async.
// R14: Fuse programmed makes C6 plain I/O; otherwise C6 feeds reset.
// R15: While C6 is reset input its direction, latch and pin read zero.
// R16: Two-wire enable takes C5 as serial clock line.
// R17: Two-wire enable takes C4 as serial data line.
// R18: Two-wire pins filter pulses under 50 ns and only pull low.
// R19: Pull-up follows override value, else on for dir 0, latch 1, disable 0.
// R20: Driver enable follows direction override value, else the direction bit.
// R21: Driven pin takes value override when enabled, else output latch.
// R22: Global pull-up disable turns off all port pull-ups; code keeps the C6 pull-up on while C6 is the reset input.
`timescale 1ns/1ps
module pamx_top (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic [pamx_pkg::PB_W-1:0] dir_bit_b,
    input  wire logic [pamx_pkg::PB_W-1:0] out_latch_b,
    input  wire logic [pamx_pkg::PB_W-1:0] pad_b_in,
    input  wire logic [pamx_pkg::PC_W-1:0] dir_bit_c,
    input  wire logic [pamx_pkg::PC_W-1:0] out_latch_c,
    input  wire logic [pamx_pkg::PC_W-1:0] pad_c_in,
    input  wire logic                      global_pullup_disable,
    input  wire logic                      sleep_input_disable,
    input  wire logic                      spi_enable,
    input  wire logic                      spi_master_select,
    input  wire logic                      spi_sck_out,
    input  wire logic                      spi_master_out,
    input  wire logic                      spi_slave_out,
    input  wire logic                      timer2_compare_out,
    input  wire logic                      timer2_compare_en,
    input  wire logic                      timer1_compare_a_out,
    input  wire logic                      timer1_compare_a_en,
    input  wire logic                      timer1_compare_b_out,
    input  wire logic                      timer1_compare_b_en,
    input  wire logic                      internal_rc_selected,
    input  wire logic                      offchip_clock_selected,
    input  wire logic                      timer2_async_select,
    input  wire logic                      reset_pin_disable_fuse,
    input  wire logic                      twowire_enable,
    input  wire logic                      twowire_scl_low,
    input  wire logic                      twowire_sda_low,
    output logic      [pamx_pkg::PB_W-1:0] pad_b_out,
    output logic      [pamx_pkg::PB_W-1:0] pad_b_oe,
    output logic      [pamx_pkg::PB_W-1:0] pad_b_pullup,
    output logic      [pamx_pkg::PB_W-1:0] pad_b_ie,
    output logic      [pamx_pkg::PC_W-1:0] pad_c_out,
    output logic      [pamx_pkg::PC_W-1:0] pad_c_oe,
    output logic      [pamx_pkg::PC_W-1:0] pad_c_pullup,
    output logic      [pamx_pkg::PC_W-1:0] pad_c_ie,
    output logic                           twowire_slew_limit,
    output logic                           twowire_scl_in,
    output logic                           twowire_sda_in,
    output logic                           spi_sck_in,
    output logic                           spi_master_in,
    output logic                           spi_slave_in,
    output logic                           spi_slave_active,
    output logic                           timer1_capture_in,
    output logic                           pin_reset_req,
    output logic      [pamx_pkg::PB_W-1:0] rd_dir_bit_b,
    output logic      [pamx_pkg::PB_W-1:0] rd_out_latch_b,
    output logic      [pamx_pkg::PB_W-1:0] rd_pin_input_b,
    output logic      [pamx_pkg::PC_W-1:0] rd_dir_bit_c,
    output logic      [pamx_pkg::PC_W-1:0] rd_out_latch_c,
    output logic      [pamx_pkg::PC_W-1:0] rd_pin_input_c
);

    localparam int BW = pamx_pkg::PB_W;
    localparam int CW = pamx_pkg::PC_W;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    logic          spi_slv;
    logic          spi_mst;
    logic          clk_b6;
    logic          clk_b7;
    logic          rst_mode;
    logic [BW-1:0] b_claim;
    logic [CW-1:0] c_claim;

    assign spi_slv  = spi_enable && !spi_master_select;
    assign spi_mst  = spi_enable && spi_master_select;
    assign clk_b6   = internal_rc_selected || timer2_async_select;  // [R12]
    assign clk_b7   = offchip_clock_selected && clk_b6;             // [R13]
    assign rst_mode = !reset_pin_disable_fuse;                      // [R14]
    assign b_claim  = {clk_b7, clk_b6, 6'h00};
    assign c_claim  = {rst_mode, 6'h00};

    // ----------------------------------------
    // Override signals per pin
    // ----------------------------------------
    logic [BW-1:0] b_pu_oe, b_pu_ov, b_dr_oe, b_dr_ov, b_vl_oe, b_vl_ov, b_ie_oe, b_ie_ov;
    logic [CW-1:0] c_pu_oe, c_pu_ov, c_dr_oe, c_dr_ov, c_vl_oe, c_vl_ov, c_ie_oe, c_ie_ov;

    always_comb
    begin
        b_pu_oe = '0;
        b_pu_ov = '0;
        b_dr_oe = '0;
        b_dr_ov = '0;
        b_vl_oe = '0;
        b_vl_ov = '0;
        b_ie_oe = '0;
        b_ie_ov = '0;
        // Clock pins: pad fully released to the oscillator
        b_pu_oe[pamx_pkg::B_XT1] = clk_b6;                          // [R12]
        b_dr_oe[pamx_pkg::B_XT1] = clk_b6;                          // [R12]
        b_ie_oe[pamx_pkg::B_XT1] = clk_b6;                          // [R12]
        b_pu_oe[pamx_pkg::B_XT2] = clk_b7;                          // [R13]
        b_dr_oe[pamx_pkg::B_XT2] = clk_b7;                          // [R13]
        b_ie_oe[pamx_pkg::B_XT2] = clk_b7;                          // [R13]
        // Inputs forced by the SPI keep a latch-driven pull-up
        b_pu_oe[pamx_pkg::B_SCK] = spi_slv;                         // [R1]
        b_dr_oe[pamx_pkg::B_SCK] = spi_slv;                         // [R1]
        b_vl_oe[pamx_pkg::B_SCK] = spi_mst;
        b_vl_ov[pamx_pkg::B_SCK] = spi_sck_out;
        b_pu_oe[pamx_pkg::B_MISO] = spi_mst;                        // [R2]
        b_dr_oe[pamx_pkg::B_MISO] = spi_mst;                        // [R2]
        b_vl_oe[pamx_pkg::B_MISO] = spi_slv;                        // [R7]
        b_vl_ov[pamx_pkg::B_MISO] = spi_slave_out;                  // [R7]
        b_pu_oe[pamx_pkg::B_MOSI] = spi_slv;                        // [R3]
        b_dr_oe[pamx_pkg::B_MOSI] = spi_slv;                        // [R3]
        b_vl_oe[pamx_pkg::B_MOSI] = spi_mst || timer2_compare_en;   // [R8]
        b_vl_ov[pamx_pkg::B_MOSI] = spi_master_out || timer2_compare_out; // [R8]
        b_pu_oe[pamx_pkg::B_SSEL] = spi_slv;                        // [R4]
        b_dr_oe[pamx_pkg::B_SSEL] = spi_slv;                        // [R4]
        b_vl_oe[pamx_pkg::B_SSEL] = timer1_compare_b_en;            // [R9]
        b_vl_ov[pamx_pkg::B_SSEL] = timer1_compare_b_out;           // [R9]
        b_vl_oe[pamx_pkg::B_T1A] = timer1_compare_a_en;             // [R10]
        b_vl_ov[pamx_pkg::B_T1A] = timer1_compare_a_out;            // [R10]
        for (int i = pamx_pkg::B_SSEL; i <= pamx_pkg::B_SCK; i++)
        begin
            b_pu_ov[i] = out_latch_b[i] && !global_pullup_disable;  // [R6]
        end
    end

    always_comb
    begin
        c_pu_oe = '0;
        c_pu_ov = '0;
        c_dr_oe = '0;
        c_dr_ov = '0;
        c_vl_oe = '0;
        c_vl_ov = '0;
        c_ie_oe = '0;
        c_ie_ov = '0;
        // Reset pin: digital path off, pull-up held on
        c_pu_oe[pamx_pkg::C_RST] = rst_mode;                        // [R14]
        c_pu_ov[pamx_pkg::C_RST] = 1'b1;
        c_dr_oe[pamx_pkg::C_RST] = rst_mode;                        // [R14]
        c_ie_oe[pamx_pkg::C_RST] = rst_mode;                        // [R14]
        // Two-wire pins: only ever pull low, never drive high
        c_pu_oe[pamx_pkg::C_SCL] = twowire_enable;                  // [R16]
        c_pu_ov[pamx_pkg::C_SCL] = out_latch_c[pamx_pkg::C_SCL] && !global_pullup_disable;
        c_dr_oe[pamx_pkg::C_SCL] = twowire_enable;                  // [R16]
        c_dr_ov[pamx_pkg::C_SCL] = twowire_scl_low;                 // [R18]
        c_vl_oe[pamx_pkg::C_SCL] = twowire_enable;                  // [R18]
        c_pu_oe[pamx_pkg::C_SDA] = twowire_enable;                  // [R17]
        c_pu_ov[pamx_pkg::C_SDA] = out_latch_c[pamx_pkg::C_SDA] && !global_pullup_disable;
        c_dr_oe[pamx_pkg::C_SDA] = twowire_enable;                  // [R17]
        c_dr_ov[pamx_pkg::C_SDA] = twowire_sda_low;                 // [R18]
        c_vl_oe[pamx_pkg::C_SDA] = twowire_enable;                  // [R18]
    end

    // ----------------------------------------
    // Pad cells
    // ----------------------------------------
    logic [BW-1:0] b_pu, b_de, b_dv, b_ie;
    logic [CW-1:0] c_pu, c_de, c_dv, c_ie;

    for (genvar i = 0; i < BW; i++)
    begin : g_pb
        pamx_pin_cell u_cell (
            .dir_bit   (dir_bit_b[i]),
            .out_latch (out_latch_b[i]),
            .global_pullup_disable (global_pullup_disable),
            .sleep_dis (sleep_input_disable),
            .pullup_override_en (b_pu_oe[i]),
            .pullup_override_val (b_pu_ov[i]),
            .dir_override_en (b_dr_oe[i]),
            .dir_override_val (b_dr_ov[i]),
            .value_override_en (b_vl_oe[i]),
            .value_override_val (b_vl_ov[i]),
            .input_enable_override_en (b_ie_oe[i]),
            .input_enable_override_val (b_ie_ov[i]),
            .pullup_en (b_pu[i]),
            .drive_en  (b_de[i]),
            .drive_val (b_dv[i]),
            .input_en  (b_ie[i])
        );
    end

    for (genvar i = 0; i < CW; i++)
    begin : g_pc
        pamx_pin_cell u_cell (
            .dir_bit   (dir_bit_c[i]),
            .out_latch (out_latch_c[i]),
            .global_pullup_disable (global_pullup_disable),
            .sleep_dis (sleep_input_disable),
            .pullup_override_en (c_pu_oe[i]),
            .pullup_override_val (c_pu_ov[i]),
            .dir_override_en (c_dr_oe[i]),
            .dir_override_val (c_dr_ov[i]),
            .value_override_en (c_vl_oe[i]),
            .value_override_val (c_vl_ov[i]),
            .input_enable_override_en (c_ie_oe[i]),
            .input_enable_override_val (c_ie_ov[i]),
            .pullup_en (c_pu[i]),
            .drive_en  (c_de[i]),
            .drive_val (c_dv[i]),
            .input_en  (c_ie[i])
        );
    end

    // ----------------------------------------
    // Registered pad controls
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            pad_b_out          <= pamx_pkg::PB_RST;
            pad_b_oe           <= pamx_pkg::PB_RST;
            pad_b_pullup       <= pamx_pkg::PB_RST;
            pad_b_ie           <= pamx_pkg::PB_RST;
            pad_c_out          <= pamx_pkg::PC_RST;
            pad_c_oe           <= pamx_pkg::PC_RST;
            pad_c_pullup       <= pamx_pkg::PC_RST;
            pad_c_ie           <= pamx_pkg::PC_RST;
            twowire_slew_limit <= 1'b0;
        end
        else
        begin
            pad_b_out          <= b_dv;                             // [R21]
            pad_b_oe           <= b_de;                             // [R20]
            pad_b_pullup       <= b_pu;                             // [R19]
            pad_b_ie           <= b_ie;
            pad_c_out          <= c_dv;
            pad_c_oe           <= c_de;
            pad_c_pullup       <= c_pu;
            pad_c_ie           <= c_ie;
            twowire_slew_limit <= twowire_enable;                   // [R18]
        end
    end

    // ----------------------------------------
    // Peripheral inputs and reset request
    // ----------------------------------------
    // Peripherals synchronise these themselves; one flop only aligns timing
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            spi_sck_in        <= 1'b0;
            spi_master_in     <= 1'b0;
            spi_slave_in      <= 1'b0;
            spi_slave_active  <= 1'b0;
            timer1_capture_in <= 1'b0;
            pin_reset_req     <= 1'b0;
        end
        else
        begin
            spi_sck_in        <= pad_b_in[pamx_pkg::B_SCK];
            spi_master_in     <= pad_b_in[pamx_pkg::B_MISO];        // [R7]
            spi_slave_in      <= pad_b_in[pamx_pkg::B_MOSI];        // [R7]
            spi_slave_active  <= spi_slv && !pad_b_in[pamx_pkg::B_SSEL]; // [R5]
            timer1_capture_in <= pad_b_in[pamx_pkg::B_CAP];         // [R11]
            pin_reset_req     <= rst_mode && !pad_c_in[pamx_pkg::C_RST]; // [R14]
        end
    end

    pamx_spike_filter #(
        .CYC  (pamx_pkg::FILT_CYC),
        .CW   (pamx_pkg::FILT_CW),
        .INIT (pamx_pkg::TW_IDLE)
    ) u_scl_filt (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .raw_in    (pad_c_in[pamx_pkg::C_SCL]),
        .clean_out (twowire_scl_in)
    );

    pamx_spike_filter #(
        .CYC  (pamx_pkg::FILT_CYC),
        .CW   (pamx_pkg::FILT_CW),
        .INIT (pamx_pkg::TW_IDLE)
    ) u_sda_filt (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .raw_in    (pad_c_in[pamx_pkg::C_SDA]),
        .clean_out (twowire_sda_in)
    );

    // ----------------------------------------
    // Read-back: pins claimed as clock or reset read zero
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rd_dir_bit_b   <= pamx_pkg::PB_RST;
            rd_out_latch_b <= pamx_pkg::PB_RST;
            rd_pin_input_b <= pamx_pkg::PB_RST;
            rd_dir_bit_c   <= pamx_pkg::PC_RST;
            rd_out_latch_c <= pamx_pkg::PC_RST;
            rd_pin_input_c <= pamx_pkg::PC_RST;
        end
        else
        begin
            rd_dir_bit_b   <= dir_bit_b & ~b_claim;
            rd_out_latch_b <= out_latch_b & ~b_claim;
            rd_pin_input_b <= pad_b_in & b_ie & ~b_claim;
            rd_dir_bit_c   <= dir_bit_c & ~c_claim;                 // [R15]
            rd_out_latch_c <= out_latch_c & ~c_claim;               // [R15]
            rd_pin_input_c <= pad_c_in & c_ie & ~c_claim;           // [R15]
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_slave;
        spi_enable && !spi_master_select;
    endsequence

    sequence s_master;
        spi_enable && spi_master_select;
    endsequence

    a_sck_slave_in: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
        s_slave |=> !pad_b_oe[5])
        else $error("clock pin driven in slave mode");

    a_miso_master_in: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
        s_master |=> !pad_b_oe[4] && spi_master_in == $past(pad_b_in[4]))
        else $error("data-in pin not an input in master mode");

    a_mosi_slave_in: assert property (@(posedge core_clk) disable iff (!resetn) // [R3]
        s_slave |=> !pad_b_oe[3])
        else $error("data-out pin driven in slave mode");

    a_ssel_active: assert property (@(posedge core_clk) disable iff (!resetn) // [R5]
        (s_slave ##0 !pad_b_in[2]) |=> spi_slave_active && !pad_b_oe[2])
        else $error("slave not active on low select");

    a_forced_pullup: assert property (@(posedge core_clk) disable iff (!resetn) // [R6]
        s_slave |=> pad_b_pullup[5] == $past(out_latch_b[5] && !global_pullup_disable))
        else $error("forced input pull-up not from latch");

    a_oc2_value: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
        (timer2_compare_en && dir_bit_b[3] && !spi_enable)
        |=> pad_b_oe[3] && pad_b_out[3] == $past(spi_master_out || timer2_compare_out))
        else $error("compare waveform wrong on B3");

    a_osc_pin_off: assert property (@(posedge core_clk) disable iff (!resetn) // [R12]
        timer2_async_select |=> !pad_b_oe[6] && !pad_b_pullup[6] && !pad_b_ie[6])
        else $error("oscillator pin not released");

    a_reset_readback: assert property (@(posedge core_clk) disable iff (!resetn) // [R15]
        !reset_pin_disable_fuse
        |=> !rd_dir_bit_c[6] && !rd_out_latch_c[6] && !rd_pin_input_c[6])
        else $error("reset pin read-back not zero");

    a_tw_open_drain: assert property (@(posedge core_clk) disable iff (!resetn) // [R18]
        twowire_enable |=> !(pad_c_oe[5] && pad_c_out[5]) && !(pad_c_oe[4] && pad_c_out[4]))
        else $error("two-wire pin driven high");

    a_tw_filter: assert property (@(posedge core_clk) disable iff (!resetn) // [R18]
        $rose(twowire_scl_in) |-> $past(pad_c_in[5], 1) && $past(pad_c_in[5], 5))
        else $error("short pulse passed the filter");

    a_pud_global: assert property (@(posedge core_clk) disable iff (!resetn) // [R22]
        global_pullup_disable |=> pad_b_pullup == 8'h00)
        else $error("pull-up on despite global disable");

endmodule : pamx_top

// >>> pkg/pamx_pkg.sv
package pamx_pkg;

    // ----------------------------------------
    // Port widths and pin positions
    // ----------------------------------------
    localparam int PB_W   = 8;
    localparam int PC_W   = 7;
    localparam int B_CAP  = 0;
    localparam int B_T1A  = 1;
    localparam int B_SSEL = 2;
    localparam int B_MOSI = 3;
    localparam int B_MISO = 4;
    localparam int B_SCK  = 5;
    localparam int B_XT1  = 6;
    localparam int B_XT2  = 7;
    localparam int C_SDA  = 4;
    localparam int C_SCL  = 5;
    localparam int C_RST  = 6;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [PB_W-1:0] PB_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 7'h00;
    localparam logic            TW_IDLE = 1'b1;

    // ----------------------------------------
    // Spike filter timing
    // ----------------------------------------
    localparam int FILT_NS  = 50;
    localparam int CLK_NS   = 10;
    localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILT_CW  = $clog2(FILT_CYC + 1);

endpackage : pamx_pkg

// >>> core/pamx_pin_cell.sv
`timescale 1ns/1ps
module pamx_pin_cell (
    input  wire logic dir_bit,
    input  wire logic out_latch,
    input  wire logic global_pullup_disable,
    input  wire logic sleep_dis,
    input  wire logic pullup_override_en,
    input  wire logic pullup_override_val,
    input  wire logic dir_override_en,
    input  wire logic dir_override_val,
    input  wire logic value_override_en,
    input  wire logic value_override_val,
    input  wire logic input_enable_override_en,
    input  wire logic input_enable_override_val,
    output logic      pullup_en,
    output logic      drive_en,
    output logic      drive_val,
    output logic      input_en
);

    // ----------------------------------------
    // Override resolution for one pad
    // ----------------------------------------
    assign pullup_en = pullup_override_en ? pullup_override_val :         // [R19]
                       (!dir_bit && out_latch && !global_pullup_disable); // [R22]
    assign drive_en  = dir_override_en ? dir_override_val : dir_bit;      // [R20]
    assign drive_val = (value_override_en && drive_en) ? value_override_val : out_latch; // [R21]
    assign input_en  = input_enable_override_en ? input_enable_override_val : !sleep_dis;

endmodule : pamx_pin_cell

// >>> core/pamx_spike_filter.sv
`timescale 1ns/1ps
module pamx_spike_filter #(
    parameter int   CYC  = 5,
    parameter int   CW   = 3,
    parameter logic INIT = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic raw_in,
    output logic      clean_out
);

    // ----------------------------------------
    // Accept a new level only after CYC stable cycles
    // ----------------------------------------
    logic [CW-1:0] cnt_r;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            cnt_r     <= '0;
            clean_out <= INIT;
        end
        else if (raw_in == clean_out)
        begin
            cnt_r <= '0;
        end
        else if (cnt_r == CW'(CYC - 1))
        begin
            cnt_r     <= '0;
            clean_out <= raw_in; // [R18]
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

endmodule : pamx_spike_filter

// >>> sim/pamx_periph_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Peripheral side: SPI, timers, two-wire
// ----------------------------------------
module pamx_periph_model (
    input  wire logic        core_clk,
    input  wire logic [10:0] periph_pat,
    output logic             spi_sck_out,
    output logic             spi_master_out,
    output logic             spi_slave_out,
    output logic             timer2_compare_out,
    output logic             timer2_compare_en,
    output logic             timer1_compare_a_out,
    output logic             timer1_compare_a_en,
    output logic             timer1_compare_b_out,
    output logic             timer1_compare_b_en,
    output logic             twowire_scl_low,
    output logic             twowire_sda_low
);
    // Updates on the falling edge so values are settled when the mux samples them
    always @(negedge core_clk)
    begin
        {twowire_sda_low, twowire_scl_low, timer1_compare_b_en, timer1_compare_b_out,
         timer1_compare_a_en, timer1_compare_a_out, timer2_compare_en, timer2_compare_out,
         spi_slave_out, spi_master_out, spi_sck_out} <= periph_pat;
    end
endmodule : pamx_periph_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        core_clk, resetn, global_pullup_disable, sleep_input_disable;
    logic        spi_enable, spi_master_select, internal_rc_selected, offchip_clock_selected;
    logic        timer2_async_select, reset_pin_disable_fuse, twowire_enable;
    logic [7:0]  dir_bit_b, out_latch_b, pad_b_in, pad_b_out, pad_b_oe, pad_b_pullup, pad_b_ie;
    logic [7:0]  rd_dir_bit_b, rd_out_latch_b, rd_pin_input_b;
    logic [6:0]  dir_bit_c, out_latch_c, pad_c_in, pad_c_out, pad_c_oe, pad_c_pullup, pad_c_ie;
    logic [6:0]  rd_dir_bit_c, rd_out_latch_c, rd_pin_input_c;
    logic [10:0] periph_pat;
    logic        spi_sck_out, spi_master_out, spi_slave_out, timer2_compare_out;
    logic        timer2_compare_en, timer1_compare_a_out, timer1_compare_a_en;
    logic        timer1_compare_b_out, timer1_compare_b_en, twowire_scl_low, twowire_sda_low;
    logic        twowire_slew_limit, twowire_scl_in, twowire_sda_in, spi_sck_in;
    logic        spi_master_in, spi_slave_in, spi_slave_active, timer1_capture_in;
    logic        pin_reset_req;
    int          fail_count, n_tests, n;

    pamx_top          dut_u (.*);
    pamx_periph_model per_u (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Two falling edges: one for the peripheral model, one for the registered mux
    task automatic settle;
        repeat (2) @(negedge core_clk);
    endtask : settle

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {global_pullup_disable, sleep_input_disable, spi_enable, spi_master_select} = 4'h0;
        {internal_rc_selected, offchip_clock_selected, timer2_async_select} = 3'h0;
        {reset_pin_disable_fuse, twowire_enable, resetn} = 3'h0;
        {dir_bit_b, out_latch_b, pad_b_in} = 24'h0000ff;
        {dir_bit_c, out_latch_c, pad_c_in} = 21'h7f;
        periph_pat = 11'h000;
        fail_count = 0;
        n_tests = 0;
        repeat (16) @(negedge core_clk);
        chk(twowire_scl_in, 8'h01);
        resetn = 1'b1;
        spi_enable = 1'b1;
        dir_bit_b = 8'h3f;
        out_latch_b = 8'h2c;
        periph_pat <= 11'h004;
        settle();
        chk(pad_b_oe, 8'h13);
        chk(pad_b_pullup, 8'h2c);
        chk(pad_b_out, 8'h3c);
        pad_b_in = 8'hdb;
        settle();
        chk(spi_slave_active, 8'h01);
        chk(spi_slave_in, 8'h01);
        chk(spi_sck_in, 8'h00);
        pad_b_in = 8'hff;
        settle();
        chk(spi_slave_active, 8'h00);
        $display("test spi slave done");
        spi_master_select = 1'b1;
        global_pullup_disable = 1'b1;
        out_latch_b = 8'h10;
        pad_b_in = 8'hef;
        periph_pat <= 11'h003;
        settle();
        chk(pad_b_oe, 8'h2f);
        chk(pad_b_pullup, 8'h00);
        chk(pad_b_out & 8'h28, 8'h28);
        chk(spi_master_in, 8'h00);
        $display("test spi master done");
        {spi_enable, global_pullup_disable} = 2'h0;
        dir_bit_b = 8'h0e;
        out_latch_b = 8'h01;
        pad_b_in = 8'h01;
        periph_pat <= 11'h1fa;
        settle();
        chk(pad_b_out, 8'h0f);
        chk(pad_b_pullup, 8'h01);
        chk(timer1_capture_in, 8'h01);
        dir_bit_b = 8'h06;
        settle();
        chk(pad_b_oe, 8'h06);
        $display("test timers done");
        dir_bit_b = 8'h41;
        out_latch_b = 8'hc0;
        pad_b_in = 8'hc1;
        internal_rc_selected = 1'b1;
        settle();
        chk(pad_b_pullup, 8'h80);
        chk(pad_b_ie, 8'hbf);
        chk(rd_dir_bit_b | rd_out_latch_b, 8'h81);
        chk(rd_pin_input_b, 8'h81);
        {internal_rc_selected, timer2_async_select, offchip_clock_selected} = 3'h3;
        settle();
        chk(pad_b_pullup, 8'h00);
        chk(pad_b_ie, 8'h3f);
        $display("test clock pins done");
        {dir_bit_c, out_latch_c, pad_c_in} = {7'h40, 7'h40, 7'h3f};
        settle();
        chk({rd_dir_bit_c, 1'b0} | rd_out_latch_c, 8'h00);
        chk(rd_pin_input_c, 8'h3f);
        chk(pin_reset_req, 8'h01);
        chk(pad_c_pullup, 8'h40);
        chk(pad_c_ie, 8'h3f);
        {reset_pin_disable_fuse, sleep_input_disable} = 2'h3;
        settle();
        chk(rd_dir_bit_c, 8'h40);
        chk(pad_c_ie, 8'h00);
        chk(pad_c_oe, 8'h40);
        chk(pin_reset_req, 8'h00);
        $display("test reset pin done");
        {dir_bit_c, out_latch_c, pad_c_in} = {7'h00, 7'h30, 7'h7f};
        twowire_enable = 1'b1;
        periph_pat <= 11'h200;
        settle();
        chk({pad_c_oe[5:4], pad_c_out[5:4], pad_c_pullup[5:4]}, 8'h27);
        chk(twowire_slew_limit, 8'h01);
        pad_c_in[5] = 1'b0;
        for (n = 0; n < 10; n++)
        begin
            @(negedge core_clk);
            pad_c_in[5] = (n >= 3);
            chk(twowire_scl_in, 8'h01);
        end
        pad_c_in[5:4] = 2'b00;
        n = 0;
        while (twowire_scl_in !== 1'b0 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n == 20)
            fail_count++;
        else
            chk(8'(n), 8'(pamx_pkg::FILT_CYC));
        chk(twowire_sda_in, 8'h00);
        pad_c_in[5] = 1'b1;
        repeat (5) @(negedge core_clk);
        chk(twowire_scl_in, 8'h01);
        $display("test two-wire done");
        give_verdict();
    end
endmodule : tb_top
